// ==== design/atm_pkg.sv ====
package atm_pkg;
    // Operand and scaling widths
    localparam int ATM_RAW_W = 16;
    localparam int ATM_GAIN_W = 16;
    localparam int ATM_VAL_W = 32;
    localparam int ATM_OUT_W = 16;
    // Internal full-scale value of an input channel
    localparam logic signed [15:0] ATM_RAW_MAX = 16'sh03E8;
    // Gain is in hundredths: 1000 means 10.00
    localparam logic signed [15:0] ATM_GAIN_LIM = 16'sh03E8;
    localparam logic signed [31:0] ATM_GAIN_DIV = 32'sh00000064;
    localparam logic signed [15:0] ATM_OFS_LIM = 16'sh2710;
    localparam logic signed [15:0] ATM_THR_LIM = 16'sh4E20;
    localparam logic [1:0] ATM_DEC_MAX = 2'h3;
    localparam logic signed [31:0] ATM_SAT_HI = 32'sh00007FFF;
    localparam logic signed [31:0] ATM_SAT_LO = 32'shFFFF8000;
    // Gain value after reset: 1.00
    localparam logic signed [15:0] ATM_GAIN_RST = 16'sh0064;

    // APB register byte offsets
    localparam logic [7:0] ATM_REG_CTRL = 8'h00;
    localparam logic [7:0] ATM_REG_GAIN = 8'h04;
    localparam logic [7:0] ATM_REG_OFS = 8'h08;
    localparam logic [7:0] ATM_REG_ON = 8'h0C;
    localparam logic [7:0] ATM_REG_OFF = 8'h10;
    localparam logic [7:0] ATM_REG_DELTA = 8'h14;
    localparam logic [7:0] ATM_REG_STAT = 8'h18;
    localparam logic [7:0] ATM_REG_RESULT = 8'h1C;
    localparam logic [7:0] ATM_REG_REF = 8'h20;
    // CTRL field positions
    localparam int ATM_CTRL_SEL_LSB = 0;
    localparam int ATM_CTRL_ONSRC = 4;
    localparam int ATM_CTRL_OFFSRC = 5;
    localparam int ATM_CTRL_DEC_LSB = 8;
    localparam int ATM_CTRL_ADJ = 12;
    localparam int ATM_CTRL_RUN = 13;
    localparam logic [31:0] ATM_CTRL_RST = 32'h00000000;
    localparam logic [31:0] ATM_CTRL_MASK = 32'h0000333F;
endpackage

// ==== design/atm_scale_if.sv ====
`timescale 1ns/1ps
interface atm_scale_if;
    logic signed [15:0] raw;
    logic signed [15:0] gain;
    logic signed [15:0] offset;
    logic signed [31:0] actual;
    modport master (output raw, output gain, output offset, input actual);
    modport scaler (input raw, input gain, input offset, output actual);
endinterface

// ==== design/atm_scale.sv ====
`timescale 1ns/1ps
module atm_scale (
    atm_scale_if.scaler s
);
    import atm_pkg::*;
    logic signed [31:0] prod;
    always_comb begin
        // Gain is in hundredths, so the product is divided back
        prod = (32'(s.raw) * 32'(s.gain)) / ATM_GAIN_DIV;
        s.actual = prod + 32'(s.offset); // [RQ2]
    end
endmodule

// ==== design/atm_top.sv ====
// Contract
// [RQ1] Operand is an input or output channel, 0-1000; code passes the whole signed 16-bit channel word, not limited to ATM_RAW_MAX
// [RQ2] Actual value equals raw times gain plus offset
// [RQ3] Gain within 10.00, offset within 10000
// [RQ4] On and off thresholds within 20000
// [RQ5] On not below off: set above on
// [RQ6] On not below off: clear at or below off
// [RQ7] On below off: set inside on..off window
// [RQ8] Decimals only for display, not comparison
// [RQ9] Threshold from constant or another block
// [RQ10] Thresholds and decimals writable in adjust mode
// [RQ11] Amplifier drives signed 16-bit scaled value
// [RQ12] Amplifier offset 10000, gain 10 limits
// [RQ13] Enable rising edge captures reference operand
// [RQ14] Same scaling for reference and live value
// [RQ15] Monitor set when outside reference plus delta band
// [RQ16] Monitor clear inside band or enable low
// [RQ17] Delta within 20000
// [RQ18] Between thresholds hold previous output
// [RQ19] Evaluate once per scan, edge against last
// [RQ20] Amplifier saturates instead of wrapping
`timescale 1ns/1ps
module atm_top #(
    parameter int N_IN = 8,
    parameter int N_OUT = 2
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic scan_tick,
    input wire logic monitor_enable,
    input wire logic [N_IN*16-1:0] analog_input_channels,
    input wire logic [N_OUT*16-1:0] analog_output_channels,
    input wire logic [15:0] block_on_value,
    input wire logic [15:0] block_off_value,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic trigger_out,
    output logic monitor_out,
    output logic [15:0] scaled_analog_result
);
    import atm_pkg::*;

    initial begin
        if (N_IN < 1 || N_OUT < 1 || N_IN + N_OUT > 16) begin
            $error("atm_top: channel counts out of range");
        end
    end

    typedef struct packed {
        logic [31:0] ctrl;
        logic signed [15:0] gain;
        logic signed [15:0] offset;
        logic signed [15:0] on_thr;
        logic signed [15:0] off_thr;
        logic signed [15:0] delta;
        logic signed [31:0] ref_val;
        logic en_last;
        logic watching;
        logic trig;
        logic mon;
        logic [15:0] result;
        logic [31:0] rdata;
        logic ready;
        logic err;
    } atm_state_t;

    atm_state_t cur, nxt;

    // Monitor enable and external block values come from logic on sys_clk
    atm_scale_if sc_if ();
    atm_scale u_scale (.s(sc_if));

    function automatic logic signed [15:0] clamp16(input logic signed [31:0] v, input logic signed [15:0] lim);
        if (v > 32'(lim)) begin
            clamp16 = lim;
        end else if (v < -32'(lim)) begin
            clamp16 = -lim;
        end else begin
            clamp16 = v[15:0];
        end
    endfunction

    function automatic logic sel_reg(input logic [7:0] a, input logic [7:0] r);
        sel_reg = (a == r);
    endfunction

    logic signed [15:0] operand;
    logic [3:0] sel;
    logic signed [31:0] actual;
    logic signed [31:0] on_v;
    logic signed [31:0] off_v;
    logic signed [31:0] lo_b;
    logic signed [31:0] hi_b;
    logic signed [31:0] sat;
    logic wr;
    logic rd;
    logic adj_ok;
    logic [15:0] ch_words [N_IN+N_OUT];

    genvar gi;
    generate
        for (gi = 0; gi < N_IN; gi++) begin : g_in
            assign ch_words[gi] = analog_input_channels[gi*16 +: 16];
        end
        for (gi = 0; gi < N_OUT; gi++) begin : g_out
            assign ch_words[N_IN+gi] = analog_output_channels[gi*16 +: 16];
        end
    endgenerate

    assign sel = cur.ctrl[ATM_CTRL_SEL_LSB +: 4];
    always_comb begin
        operand = 16'sh0000;
        if (32'(sel) < N_IN + N_OUT) begin
            operand = ch_words[sel]; // [RQ1]
        end
    end

    assign sc_if.raw = operand;
    assign sc_if.gain = cur.gain;
    assign sc_if.offset = cur.offset;
    assign actual = sc_if.actual; // [RQ14]

    always_comb begin
        // Threshold from a constant or from another block's result
        on_v = cur.ctrl[ATM_CTRL_ONSRC] ? 32'(signed'(block_on_value)) : 32'(cur.on_thr); // [RQ9]
        off_v = cur.ctrl[ATM_CTRL_OFFSRC] ? 32'(signed'(block_off_value)) : 32'(cur.off_thr); // [RQ9]
        lo_b = cur.ref_val - 32'(cur.delta);
        hi_b = cur.ref_val + 32'(cur.delta);
        if (lo_b > hi_b) begin
            lo_b = cur.ref_val + 32'(cur.delta);
            hi_b = cur.ref_val - 32'(cur.delta);
        end
        if (actual > ATM_SAT_HI) begin
            sat = ATM_SAT_HI; // [RQ20]
        end else if (actual < ATM_SAT_LO) begin
            sat = ATM_SAT_LO; // [RQ20]
        end else begin
            sat = actual;
        end
    end

    // Write lands at the completing edge, where the master sees pready high
    assign wr = psel && penable && pwrite && cur.ready;
    assign rd = psel && !penable && !pwrite;
    // Scaling is fixed while running; thresholds also in adjust mode
    assign adj_ok = !cur.ctrl[ATM_CTRL_RUN] || cur.ctrl[ATM_CTRL_ADJ];

    always_comb begin
        nxt = cur;
        nxt.ready = psel && penable && !cur.ready;
        nxt.err = 1'b0;
        if (psel && penable && !cur.ready) begin
            if (!(sel_reg(paddr, ATM_REG_CTRL) || sel_reg(paddr, ATM_REG_GAIN) || sel_reg(paddr, ATM_REG_OFS) ||
                  sel_reg(paddr, ATM_REG_ON) || sel_reg(paddr, ATM_REG_OFF) || sel_reg(paddr, ATM_REG_DELTA) ||
                  sel_reg(paddr, ATM_REG_STAT) || sel_reg(paddr, ATM_REG_RESULT) || sel_reg(paddr, ATM_REG_REF))) begin
                nxt.err = 1'b1;
            end
        end
        if (wr) begin
            if (sel_reg(paddr, ATM_REG_CTRL)) begin
                nxt.ctrl = pwdata & ATM_CTRL_MASK;
                // Decimals are only stored for display
                if (!adj_ok) begin
                    nxt.ctrl[ATM_CTRL_DEC_LSB +: 2] = cur.ctrl[ATM_CTRL_DEC_LSB +: 2]; // [RQ10]
                end
            end
            if (sel_reg(paddr, ATM_REG_GAIN) && !cur.ctrl[ATM_CTRL_RUN]) begin
                nxt.gain = clamp16(32'(signed'(pwdata[15:0])), ATM_GAIN_LIM); // [RQ3] [RQ12]
            end
            if (sel_reg(paddr, ATM_REG_OFS) && !cur.ctrl[ATM_CTRL_RUN]) begin
                nxt.offset = clamp16(32'(signed'(pwdata[15:0])), ATM_OFS_LIM); // [RQ3] [RQ12]
            end
            if (sel_reg(paddr, ATM_REG_ON) && adj_ok) begin
                nxt.on_thr = clamp16(32'(signed'(pwdata[15:0])), ATM_THR_LIM); // [RQ4] [RQ10]
            end
            if (sel_reg(paddr, ATM_REG_OFF) && adj_ok) begin
                nxt.off_thr = clamp16(32'(signed'(pwdata[15:0])), ATM_THR_LIM); // [RQ4] [RQ10]
            end
            if (sel_reg(paddr, ATM_REG_DELTA) && !cur.ctrl[ATM_CTRL_RUN]) begin
                nxt.delta = clamp16(32'(signed'(pwdata[15:0])), ATM_THR_LIM); // [RQ17]
            end
        end
        if (rd) begin
            nxt.rdata = 32'h00000000;
            case (paddr)
                ATM_REG_CTRL: nxt.rdata = cur.ctrl;
                ATM_REG_GAIN: nxt.rdata = 32'(cur.gain);
                ATM_REG_OFS: nxt.rdata = 32'(cur.offset);
                ATM_REG_ON: nxt.rdata = 32'(cur.on_thr);
                ATM_REG_OFF: nxt.rdata = 32'(cur.off_thr);
                ATM_REG_DELTA: nxt.rdata = 32'(cur.delta);
                ATM_REG_STAT: nxt.rdata = {29'h00000000, cur.watching, cur.mon, cur.trig};
                ATM_REG_RESULT: nxt.rdata = {16'h0000, cur.result};
                ATM_REG_REF: nxt.rdata = cur.ref_val;
                default: nxt.rdata = 32'h00000000;
            endcase
        end
        // Evaluation once per program scan; comparisons use scaled actual integers
        if (scan_tick) begin // [RQ19] [RQ8]
            nxt.en_last = monitor_enable;
            if (on_v >= off_v) begin
                if (actual > on_v) begin
                    nxt.trig = 1'b1; // [RQ5]
                end else if (actual <= off_v) begin
                    nxt.trig = 1'b0; // [RQ6]
                end else begin
                    nxt.trig = cur.trig; // [RQ18]
                end
            end else begin
                nxt.trig = (actual >= on_v) && (actual < off_v); // [RQ7]
            end
            nxt.result = sat[15:0]; // [RQ11]
            if (monitor_enable && !cur.en_last) begin
                nxt.ref_val = actual; // [RQ13] [RQ14]
                nxt.watching = 1'b1;
                nxt.mon = 1'b0;
            end else if (!monitor_enable) begin
                nxt.watching = 1'b0;
                nxt.mon = 1'b0; // [RQ16]
            end else if (cur.watching) begin
                nxt.mon = (actual < lo_b) || (actual > hi_b); // [RQ15] [RQ16]
            end
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cur <= '0;
            cur.ctrl <= ATM_CTRL_RST;
            cur.gain <= ATM_GAIN_RST;
        end else begin
            cur <= nxt;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            trigger_out <= 1'b0;
            monitor_out <= 1'b0;
            scaled_analog_result <= 16'h0000;
        end else begin
            prdata <= nxt.rdata;
            pready <= nxt.ready;
            pslverr <= nxt.err;
            trigger_out <= nxt.trig;
            monitor_out <= nxt.mon;
            scaled_analog_result <= nxt.result;
        end
    end

    // Threshold trigger
    hyst_set_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ5]
        scan_tick && on_v >= off_v && actual > on_v |=> trigger_out)
        else $error("trigger not set above on");
    hyst_clear_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ6]
        scan_tick && on_v >= off_v && actual <= off_v |=> !trigger_out)
        else $error("trigger not cleared at off");
    window_mode_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ7]
        scan_tick && on_v < off_v |=> trigger_out == ($past(actual) >= $past(on_v) && $past(actual) < $past(off_v)))
        else $error("window trigger wrong");
    hyst_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ18]
        scan_tick && on_v >= off_v && actual > off_v && actual <= on_v |=> trigger_out == $past(trigger_out))
        else $error("trigger did not hold");
    scan_idle_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ19]
        !scan_tick |=> $stable(trigger_out) && $stable(monitor_out) && $stable(scaled_analog_result))
        else $error("outputs moved without a scan");

    // Amplifier
    amp_sat_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ11]
        scan_tick |=> $signed(scaled_analog_result) == $past(sat[15:0]))
        else $error("amplifier output wrong");
    amp_clip_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ20]
        scan_tick && actual > ATM_SAT_HI |=> scaled_analog_result == 16'h7FFF)
        else $error("amplifier did not saturate");
    amp_floor_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ20]
        scan_tick && actual < ATM_SAT_LO |=> scaled_analog_result == 16'h8000)
        else $error("amplifier did not saturate low");

    // Window monitor
    ref_capture_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ13]
        scan_tick && monitor_enable && !cur.en_last |=> cur.ref_val == $past(actual))
        else $error("reference not captured");
    ref_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ13]
        !(scan_tick && monitor_enable && !cur.en_last) |=> $stable(cur.ref_val))
        else $error("reference changed without an edge");
    mon_low_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ16]
        scan_tick && !monitor_enable |=> !monitor_out)
        else $error("monitor not cleared");
    watch_stop_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ16]
        scan_tick && !monitor_enable |=> !cur.watching)
        else $error("monitoring did not stop");
    mon_out_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ15]
        scan_tick && monitor_enable && cur.en_last && cur.watching && (actual > hi_b || actual < lo_b)
        |=> monitor_out)
        else $error("monitor not set outside band");
    mon_inside_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ16]
        scan_tick && monitor_enable && cur.en_last && actual >= lo_b && actual <= hi_b |=> !monitor_out)
        else $error("monitor set inside band");

    // Register settings
    gain_range_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ3]
        cur.gain <= ATM_GAIN_LIM && cur.gain >= -ATM_GAIN_LIM)
        else $error("gain out of range");
    ofs_range_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ12]
        cur.offset <= ATM_OFS_LIM && cur.offset >= -ATM_OFS_LIM)
        else $error("offset out of range");
    thr_range_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ4]
        cur.on_thr <= ATM_THR_LIM && cur.on_thr >= -ATM_THR_LIM &&
        cur.off_thr <= ATM_THR_LIM && cur.off_thr >= -ATM_THR_LIM)
        else $error("threshold out of range");
    delta_range_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ17]
        cur.delta <= ATM_THR_LIM && cur.delta >= -ATM_THR_LIM)
        else $error("delta out of range");
    thr_lock_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ10]
        wr && !adj_ok |=> $stable(cur.on_thr) && $stable(cur.off_thr))
        else $error("threshold changed while locked");
    dec_lock_a: assert property (@(posedge sys_clk) disable iff (rst) // [RQ10]
        wr && sel_reg(paddr, ATM_REG_CTRL) && !adj_ok
        |=> cur.ctrl[ATM_CTRL_DEC_LSB +: 2] == $past(cur.ctrl[ATM_CTRL_DEC_LSB +: 2]))
        else $error("decimals changed while locked");

    // Register bus
    apb_ready_a: assert property (@(posedge sys_clk) disable iff (rst)
        psel && penable && !pready |=> pready)
        else $error("apb answer late");
    apb_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
        pready |=> !pready)
        else $error("apb ready held too long");
    apb_err_a: assert property (@(posedge sys_clk) disable iff (rst)
        psel && penable && !pready && paddr > ATM_REG_REF |=> pslverr && pready)
        else $error("unmapped address not refused");

    hold_c: cover property (@(posedge sys_clk) disable iff (rst)
        scan_tick && on_v >= off_v && actual > off_v && actual <= on_v && trigger_out);
    trig_rise_c: cover property (@(posedge sys_clk) disable iff (rst) $rose(trigger_out));
    mon_rise_c: cover property (@(posedge sys_clk) disable iff (rst) $rose(monitor_out));
    clip_c: cover property (@(posedge sys_clk) disable iff (rst) scan_tick && actual < ATM_SAT_LO);
    window_c: cover property (@(posedge sys_clk) disable iff (rst) scan_tick && on_v < off_v && trigger_out);
endmodule

// ==== test/atm_src_model.sv ====
`timescale 1ns/1ps
module atm_src_model #(
    parameter int N_IN = 8,
    parameter int N_OUT = 2
) (
    input wire logic sys_clk,
    output logic scan_tick,
    output logic [N_IN*16-1:0] analog_input_channels,
    output logic [N_OUT*16-1:0] analog_output_channels,
    output logic [15:0] block_on_value,
    output logic [15:0] block_off_value
);
    initial begin
        scan_tick = 1'b0;
        analog_input_channels = '0;
        analog_output_channels = '0;
        block_on_value = 16'h0000;
        block_off_value = 16'h0000;
    end
    // New sample on one channel, taken by a single-cycle scan strobe
    task automatic step(input int idx, input logic [15:0] val);
        @(posedge sys_clk);
        if (idx < N_IN) begin
            analog_input_channels[idx*16+:16] <= val;
        end else begin
            analog_output_channels[(idx-N_IN)*16+:16] <= val;
        end
        scan_tick <= 1'b1;
        @(posedge sys_clk);
        scan_tick <= 1'b0;
        @(negedge sys_clk);
    endtask
    task automatic set_blocks(input logic [15:0] on_v, input logic [15:0] off_v);
        @(posedge sys_clk);
        block_on_value <= on_v;
        block_off_value <= off_v;
    endtask
endmodule

// ==== test/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    import atm_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic monitor_enable = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic pready, pslverr, trigger_out, monitor_out, scan_tick;
    logic [15:0] scaled_analog_result, block_on_value, block_off_value;
    logic [127:0] analog_input_channels;
    logic [31:0] analog_output_channels;
    int n_fail = 0;
    int check_count = 0;
    always #2 sys_clk = ~sys_clk;
    atm_top atm_top_inst (.sys_clk(sys_clk), .rst(rst), .scan_tick(scan_tick), .monitor_enable(monitor_enable),
        .analog_input_channels(analog_input_channels), .analog_output_channels(analog_output_channels),
        .block_on_value(block_on_value), .block_off_value(block_off_value), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trigger_out(trigger_out), .monitor_out(monitor_out),
        .scaled_analog_result(scaled_analog_result));
    atm_src_model atm_src_model_inst (.sys_clk(sys_clk), .scan_tick(scan_tick),
        .analog_input_channels(analog_input_channels), .analog_output_channels(analog_output_channels),
        .block_on_value(block_on_value), .block_off_value(block_off_value));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Setup, then access held until pready is seen high at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
        output logic e);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        chk({31'h0, pready}, 32'h00000001);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        chk({31'h0, e}, 32'h00000000);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h00000000, r, e);
        chk(r, exp);
    endtask
    function automatic logic [15:0] amp(input int raw, input int g, input int o);
        int v;
        v = raw * g / 100 + o;
        if (v > 32767) v = 32767;
        if (v < -32768) v = -32768;
        return v[15:0];
    endfunction
    // One scan of channel 0, then both binary outputs compared
    task automatic ev(input logic en, input int raw, input logic [1:0] exp);
        @(posedge sys_clk);
        monitor_enable <= en;
        atm_src_model_inst.step(0, raw[15:0]);
        chk({30'h0, trigger_out, monitor_out}, {30'h0, exp});
    endtask
    task automatic conclude;
        $display("checks=%0d mismatches=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #200000;
        n_fail++;
        conclude();
    end
    initial begin
        int g, o, raw, k;
        logic [31:0] r;
        logic e;
        void'($urandom(90033));
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        rd(ATM_REG_CTRL, ATM_CTRL_RST);
        rd(ATM_REG_GAIN, 32'h00000064);
        apb(1'b0, 8'h40, 32'h00000000, r, e);
        chk(r, 32'h00000000);
        chk({31'h0, e}, 32'h00000001);
        wr(ATM_REG_GAIN, 32'h000007D0);
        rd(ATM_REG_GAIN, 32'h000003E8);
        wr(ATM_REG_OFS, 32'hFFFFC000);
        rd(ATM_REG_OFS, 32'hFFFFD8F0);
        wr(ATM_REG_DELTA, 32'hFFFF8AD0);
        rd(ATM_REG_DELTA, 32'hFFFFB1E0);
        wr(ATM_REG_ON, 32'h00005DC0);
        rd(ATM_REG_ON, 32'h00004E20);
        $display("test registers done");
        for (int i = 0; i < 24; i++) begin
            g = (i == 1) ? -1000 : (i < 4) ? 1000 : int'($urandom_range(2000)) - 1000;
            o = (i == 0) ? 10000 : (i == 1) ? -10000 : int'($urandom_range(20000)) - 10000;
            raw = (i < 2) ? 1000 : (i == 2) ? 32767 : (i == 3) ? -32768 : int'($urandom_range(1000));
            k = (i < 10) ? i : int'($urandom_range(9));
            wr(ATM_REG_CTRL, 32'(k));
            wr(ATM_REG_GAIN, 32'(g));
            wr(ATM_REG_OFS, 32'(o));
            atm_src_model_inst.step(k, raw[15:0]);
            chk({16'h0, scaled_analog_result}, {16'h0, amp(raw, g, o)});
            rd(ATM_REG_RESULT, {16'h0, amp(raw, g, o)});
        end
        $display("test amplifier done");
        wr(ATM_REG_CTRL, 32'h00000300);
        wr(ATM_REG_GAIN, 32'h00000064);
        wr(ATM_REG_OFS, 32'h00000000);
        wr(ATM_REG_ON, 32'h000001F4);
        wr(ATM_REG_OFF, 32'h000000C8);
        ev(1'b0, 600, 2'b10);
        ev(1'b0, 300, 2'b10);
        ev(1'b0, 200, 2'b00);
        ev(1'b0, 300, 2'b00);
        ev(1'b0, 501, 2'b10);
        ev(1'b0, 500, 2'b10);
        wr(ATM_REG_ON, 32'h000000C8);
        wr(ATM_REG_OFF, 32'h000001F4);
        ev(1'b0, 300, 2'b10);
        ev(1'b0, 500, 2'b00);
        ev(1'b0, 200, 2'b10);
        ev(1'b0, 199, 2'b00);
        $display("test trigger done");
        wr(ATM_REG_CTRL, 32'h00000030);
        atm_src_model_inst.set_blocks(16'h012C, 16'h0064);
        ev(1'b0, 301, 2'b10);
        ev(1'b0, 150, 2'b10);
        ev(1'b0, 100, 2'b00);
        wr(ATM_REG_CTRL, 32'h00002000);
        wr(ATM_REG_CTRL, 32'h00002300);
        rd(ATM_REG_CTRL, 32'h00002000);
        wr(ATM_REG_ON, 32'h00000064);
        rd(ATM_REG_ON, 32'h000000C8);
        wr(ATM_REG_GAIN, 32'h00000032);
        rd(ATM_REG_GAIN, 32'h00000064);
        wr(ATM_REG_CTRL, 32'h00003000);
        wr(ATM_REG_CTRL, 32'h00003200);
        rd(ATM_REG_CTRL, 32'h00003200);
        wr(ATM_REG_ON, 32'h00000064);
        rd(ATM_REG_ON, 32'h00000064);
        $display("test sources done");
        wr(ATM_REG_CTRL, 32'h00000000);
        wr(ATM_REG_ON, 32'h00004E20);
        wr(ATM_REG_OFF, 32'h00004E20);
        wr(ATM_REG_GAIN, 32'h000000C8);
        wr(ATM_REG_OFS, 32'h0000000A);
        wr(ATM_REG_DELTA, 32'h00000032);
        ev(1'b0, 400, 2'b00);
        ev(1'b1, 400, 2'b00);
        rd(ATM_REG_REF, 32'h0000032A);
        ev(1'b1, 430, 2'b01);
        rd(ATM_REG_STAT, 32'h00000006);
        ev(1'b1, 420, 2'b00);
        ev(1'b1, 370, 2'b01);
        ev(1'b0, 370, 2'b00);
        ev(1'b1, 370, 2'b00);
        rd(ATM_REG_REF, 32'h000002EE);
        ev(1'b1, 430, 2'b01);
        $display("test monitor done");
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (3) @(posedge sys_clk);
        rst <= 1'b0;
        chk({30'h0, trigger_out, monitor_out}, 32'h00000000);
        chk({16'h0, scaled_analog_result}, 32'h00000000);
        rd(ATM_REG_REF, 32'h00000000);
        rd(ATM_REG_GAIN, 32'h00000064);
        $display("test reset done");
        conclude();
    end
endmodule
